// >>> rtl/pwc_map.svh
/*
  Register offsets, field positions, reset values and encodings of the
  pulse width capture timer.
  Assumes: included by its bare name from files that need the numbers.
*/
`ifndef PWC_MAP_SVH
`define PWC_MAP_SVH

// Byte addresses on APB
`define PWC_ADDR_CTL0        32'hFFFFF300
`define PWC_ADDR_CTL1        32'hFFFFF304
`define PWC_ADDR_SEL         32'hFFFFF308
`define PWC_ADDR_IOC1        32'hFFFFF30C
`define PWC_ADDR_OPT0        32'hFFFFF310
`define PWC_ADDR_CNT         32'hFFFFF314
`define PWC_ADDR_CCR0        32'hFFFFF318
`define PWC_ADDR_CCR1        32'hFFFFF31C
`define PWC_ADDR_IOC0        32'hFFFFF320

// Reset values and counter clear and top values
`define PWC_RST_BYTE         8'h00
`define PWC_RST_WORD         16'h0000
`define PWC_CNT_STOPPED      16'hFFFF
`define PWC_CNT_CLEAR        16'h0000
`define PWC_CNT_TOP          16'hFFFF

// timer_control_0 fields
`define PWC_CE_POS           7
`define PWC_CKS_LSB          0
`define PWC_CKS_MSB          2
// timer_control_1 fields
`define PWC_MD_LSB           0
`define PWC_MD_MSB           2
`define PWC_MODE_PULSE_WIDTH 3'h6
// edge_select_control fields
`define PWC_IS0_LSB          0
`define PWC_IS1_LSB          2
`define PWC_EDGE_NONE        2'h0
`define PWC_EDGE_RISE        2'h1
`define PWC_EDGE_FALL        2'h2
`define PWC_EDGE_BOTH        2'h3
// timer_option fields
`define PWC_OVF_POS          0
`define PWC_CCS_LSB          4
// capture_source_select fields
`define PWC_ISEL0_POS        3
`define PWC_ISEL1_POS        4
// output_control fields
`define PWC_OE0_POS          0
`define PWC_OL0_POS          1
`define PWC_OE1_POS          2
`define PWC_OL1_POS          3

`endif

// >>> rtl/pwc_pkg.sv
/*
  Types of the pulse width capture timer: register index and state record.
  Assumes: compiled before the timer module; nothing imports it.
*/
`default_nettype none
package pwc_pkg;

  typedef enum logic [3:0] {
    PWC_R_CTL0,
    PWC_R_CTL1,
    PWC_R_SEL,
    PWC_R_IOC1,
    PWC_R_OPT0,
    PWC_R_CNT,
    PWC_R_CCR0,
    PWC_R_CCR1,
    PWC_R_IOC0,
    PWC_R_NONE
  } pwc_reg_e;

  typedef struct packed {
    logic [7:0]  ctl0;
    logic [7:0]  ctl1;
    logic [7:0]  ioc0;
    logic [7:0]  ioc1;
    logic [1:0]  ccs;
    logic        ovf;
    logic [1:0]  route;
    logic [15:0] cnt;
    logic [15:0] ccr0;
    logic [15:0] ccr1;
    logic [6:0]  presc;
    logic        started;
    logic [3:0]  sync1;
    logic [3:0]  sync2;
    logic [1:0]  prev;
    logic [1:0]  pend;
    logic [1:0]  cap_irq;
    logic        wrap_irq;
    logic [1:0]  tout;
    logic        pready;
    logic        pslverr;
    logic [31:0] prdata;
  } pwc_state_s;

endpackage
`default_nettype wire

// >>> rtl/pwc_timer.sv
/*
  Sixteen-bit timer channel with pulse width capture, APB registers,
  capture source selector and two timer output levels.
  Assumes: APB master on ref_clk; capture pins and serial lines are
  asynchronous and are synchronised here; one clock, no interrupt logic
  beyond the raw request pulses.
*/
// The APB interface to the registers was chosen for this implementation.
// Notes on behaviour
// - Overflow flag cleared by writing bit 0 zero
// - Mode pattern 110 selects pulse width measurement
// - Counter runs while count enable is one
// - Valid edge copies counter, then clears it
// - Capture raises that channel's capture request
// - Wrap after FFFFH raises overflow request, restarts
// - Wrap sets sticky overflow flag
// - Control 0 holds clock select and enable
// - Edge select fields per capture input
// - Counter readback returns count while running, zero when stopped, undisturbed
// - Output pin level follows level, enable, run
// - Pulse width mode drives no toggling output
// - Selector resets zero, routes serial lines
// - Early trigger may capture FFFFH or nothing
// - Selector takes byte and bit accesses
`timescale 1ns/1ps
`include "pwc_map.svh"
`default_nettype none
module pwc_timer (
  // Clock and reset
  input  wire logic        ref_clk,
  input  wire logic        rstn,
  // APB slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [31:0] paddr,
  input  wire logic [31:0] pwdata,
  input  wire logic [3:0]  pstrb,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // Capture sources
  input  wire logic        capture_input_0,
  input  wire logic        capture_input_1,
  input  wire logic        serial0_receive_line,
  input  wire logic        serial1_receive_line,
  // Requests and timer outputs
  output logic      [1:0]  capture_irq,
  output logic             wrap_irq,
  output logic      [1:0]  timer_output_pin
);

  pwc_pkg::pwc_state_s st_r;
  pwc_pkg::pwc_state_s st_nxt;

  logic [1:0]       sel_line;
  logic [1:0]       edge_hit;
  logic             ce;
  logic             pw_mode;
  logic [6:0]       tick_mask;
  logic             tick;
  logic             setup_ph;
  logic             access_ph;
  pwc_pkg::pwc_reg_e rd_idx;
  logic [31:0]      rd_val;

  // Address decode shared by read and write
  function automatic pwc_pkg::pwc_reg_e reg_index(input logic [31:0] a);
    unique case (a)
      `PWC_ADDR_CTL0: reg_index = pwc_pkg::PWC_R_CTL0;
      `PWC_ADDR_CTL1: reg_index = pwc_pkg::PWC_R_CTL1;
      `PWC_ADDR_SEL:  reg_index = pwc_pkg::PWC_R_SEL;
      `PWC_ADDR_IOC1: reg_index = pwc_pkg::PWC_R_IOC1;
      `PWC_ADDR_OPT0: reg_index = pwc_pkg::PWC_R_OPT0;
      `PWC_ADDR_CNT:  reg_index = pwc_pkg::PWC_R_CNT;
      `PWC_ADDR_CCR0: reg_index = pwc_pkg::PWC_R_CCR0;
      `PWC_ADDR_CCR1: reg_index = pwc_pkg::PWC_R_CCR1;
      `PWC_ADDR_IOC0: reg_index = pwc_pkg::PWC_R_IOC0;
      default:        reg_index = pwc_pkg::PWC_R_NONE;
    endcase
  endfunction

  // Byte-lane merge for sixteen-bit registers
  function automatic logic [15:0] merge16(input logic [15:0] old,
                                          input logic [31:0] wd,
                                          input logic [3:0]  sb);
    merge16 = old;
    if (sb[0]) begin
      merge16[7:0] = wd[7:0];
    end
    if (sb[1]) begin
      merge16[15:8] = wd[15:8];
    end
  endfunction

  // Edge match against a two-bit edge selection
  function automatic logic edge_match(input logic [1:0] es,
                                      input logic       now,
                                      input logic       old);
    unique case (es)
      `PWC_EDGE_RISE: edge_match = now & ~old;
      `PWC_EDGE_FALL: edge_match = ~now & old;
      `PWC_EDGE_BOTH: edge_match = now ^ old;
      default:        edge_match = 1'b0;
    endcase
  endfunction

  // Selected capture lines from the second synchroniser stage
  assign sel_line[0] = st_r.route[0] ? st_r.sync2[2] : st_r.sync2[0];
  assign sel_line[1] = st_r.route[1] ? st_r.sync2[3] : st_r.sync2[1];

  assign ce      = st_r.ctl0[`PWC_CE_POS];
  assign pw_mode = (st_r.ctl1[`PWC_MD_MSB:`PWC_MD_LSB] == `PWC_MODE_PULSE_WIDTH);

  // Prescaler: count step every 2^clock_select cycles
  assign tick_mask = 7'((8'h01 << st_r.ctl0[`PWC_CKS_MSB:`PWC_CKS_LSB]) - 8'h01);
  assign tick      = ce && ((st_r.presc & tick_mask) == tick_mask);

  assign setup_ph  = psel & ~penable;
  assign access_ph = psel & penable & st_r.pready;
  assign rd_idx    = reg_index(paddr);

  // Read mux
  always_comb begin
    rd_val = 32'h00000000;
    unique case (rd_idx)
      pwc_pkg::PWC_R_CTL0: rd_val[7:0] = st_r.ctl0;
      pwc_pkg::PWC_R_CTL1: rd_val[7:0] = st_r.ctl1;
      pwc_pkg::PWC_R_SEL: begin
        rd_val[`PWC_ISEL0_POS] = st_r.route[0];
        rd_val[`PWC_ISEL1_POS] = st_r.route[1];
      end
      pwc_pkg::PWC_R_IOC1: rd_val[7:0] = st_r.ioc1;
      pwc_pkg::PWC_R_OPT0: begin
        rd_val[`PWC_CCS_LSB+1:`PWC_CCS_LSB] = st_r.ccs;
        rd_val[`PWC_OVF_POS] = st_r.ovf;
      end
      pwc_pkg::PWC_R_CNT:  rd_val[15:0] = ce ? st_r.cnt : `PWC_CNT_CLEAR;
      pwc_pkg::PWC_R_CCR0: rd_val[15:0] = st_r.ccr0;
      pwc_pkg::PWC_R_CCR1: rd_val[15:0] = st_r.ccr1;
      pwc_pkg::PWC_R_IOC0: rd_val[7:0] = st_r.ioc0;
      default:             rd_val = 32'h00000000;
    endcase
  end

  // Next state
  always_comb begin
    st_nxt          = st_r;
    st_nxt.cap_irq  = 2'h0;
    st_nxt.wrap_irq = 1'b0;

    // Two-stage synchronisers, then edge history of the selected lines
    st_nxt.sync1 = {serial1_receive_line, serial0_receive_line,
                    capture_input_1, capture_input_0};
    st_nxt.sync2 = st_r.sync1;
    st_nxt.prev  = sel_line;

    // APB answer prepared in the setup cycle
    st_nxt.pready  = setup_ph;
    st_nxt.pslverr = setup_ph && (rd_idx == pwc_pkg::PWC_R_NONE);
    st_nxt.prdata  = (setup_ph && !pwrite) ? rd_val : 32'h00000000;

    // Register writes, taken at the access edge
    if (access_ph && pwrite) begin
      unique case (rd_idx)
        pwc_pkg::PWC_R_CTL0: begin
          if (pstrb[0]) begin
            st_nxt.ctl0 = pwdata[7:0];
          end
        end
        pwc_pkg::PWC_R_CTL1: begin
          if (pstrb[0]) begin
            st_nxt.ctl1 = pwdata[7:0];
          end
        end
        pwc_pkg::PWC_R_SEL: begin
          if (pstrb[0]) begin
            st_nxt.route = {pwdata[`PWC_ISEL1_POS], pwdata[`PWC_ISEL0_POS]};
          end
        end
        pwc_pkg::PWC_R_IOC1: begin
          if (pstrb[0]) begin
            st_nxt.ioc1 = pwdata[7:0];
          end
        end
        pwc_pkg::PWC_R_OPT0: begin
          if (pstrb[0]) begin
            st_nxt.ccs = pwdata[`PWC_CCS_LSB+1:`PWC_CCS_LSB];
            st_nxt.ovf = st_r.ovf & pwdata[`PWC_OVF_POS];
          end
        end
        pwc_pkg::PWC_R_CCR0: st_nxt.ccr0 = merge16(st_r.ccr0, pwdata, pstrb);
        pwc_pkg::PWC_R_CCR1: st_nxt.ccr1 = merge16(st_r.ccr1, pwdata, pstrb);
        pwc_pkg::PWC_R_IOC0: begin
          if (pstrb[0]) begin
            st_nxt.ioc0 = pwdata[7:0];
          end
        end
        default: st_nxt.ctl0 = st_r.ctl0;
      endcase
    end

    // Valid edges wait for the next count step
    for (int i = 0; i < 2; i++) begin
      edge_hit[i] = edge_match(st_r.ioc1[2*i+1 -: 2], sel_line[i], st_r.prev[i]);
    end
    st_nxt.pend = (ce && pw_mode) ? (st_r.pend | edge_hit) : 2'h0;

    // Counter
    st_nxt.presc = ce ? 7'(st_r.presc + 7'h01) : 7'h00;
    if (!ce) begin
      st_nxt.cnt     = `PWC_CNT_STOPPED;
      st_nxt.started = 1'b0;
    end else if (tick) begin
      if (!st_r.started) begin
        // First step leaves the stopped value; a pending edge captures FFFFH
        st_nxt.cnt     = `PWC_CNT_CLEAR;
        st_nxt.started = 1'b1;
        if (pw_mode && (st_r.pend != 2'h0)) begin
          st_nxt.ccr0    = st_r.pend[0] ? st_r.cnt : st_nxt.ccr0;
          st_nxt.ccr1    = st_r.pend[1] ? st_r.cnt : st_nxt.ccr1;
          st_nxt.cap_irq = st_r.pend;
          st_nxt.pend    = edge_hit;
        end
      end else if (pw_mode && (st_r.pend != 2'h0)) begin
        st_nxt.ccr0    = st_r.pend[0] ? st_r.cnt : st_nxt.ccr0;
        st_nxt.ccr1    = st_r.pend[1] ? st_r.cnt : st_nxt.ccr1;
        st_nxt.cnt     = `PWC_CNT_CLEAR;
        st_nxt.cap_irq = st_r.pend;
        st_nxt.pend    = edge_hit;
      end else if (st_r.cnt == `PWC_CNT_TOP) begin
        st_nxt.cnt      = `PWC_CNT_CLEAR;
        st_nxt.wrap_irq = 1'b1;
        st_nxt.ovf      = 1'b1;
      end else begin
        st_nxt.cnt = 16'(st_r.cnt + 16'h0001);
      end
    end

    // Output levels: enabled and running inverts the idle level
    st_nxt.tout[0] = st_r.ioc0[`PWC_OL0_POS] ^ (st_r.ioc0[`PWC_OE0_POS] & ce);
    st_nxt.tout[1] = st_r.ioc0[`PWC_OL1_POS] ^ (st_r.ioc0[`PWC_OE1_POS] & ce);
  end

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign prdata           = st_r.prdata;
  assign pready           = st_r.pready;
  assign pslverr          = st_r.pslverr;
  assign capture_irq      = st_r.cap_irq;
  assign wrap_irq         = st_r.wrap_irq;
  assign timer_output_pin = st_r.tout;

  // Checks
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rstn);

  sequence s_cap0_step;
    tick && st_r.started && pw_mode && st_r.pend[0];
  endsequence

  sequence s_cap0_done;
    st_r.cap_irq[0] && (st_r.cnt == 16'h0000);
  endsequence

  a_capture_copy: assert property (s_cap0_step |=> s_cap0_done ##0
      (st_r.ccr0 == $past(st_r.cnt)))
    else $error("capture did not copy and clear counter");

  a_capture_irq: assert property (st_r.cap_irq[1] |-> $past(st_r.pend[1])
      && $past(tick))
    else $error("capture request without pending edge");

  a_mode_gate: assert property (!pw_mode |=> st_r.pend == 2'h0)
    else $error("edge pending outside pulse width mode");

  a_stop_hold: assert property (!ce |=> st_r.cnt == 16'hFFFF)
    else $error("stopped counter not at FFFFH");

  a_wrap_event: assert property (tick && st_r.started && !(pw_mode && st_r.pend != 2'h0)
      && st_r.cnt == 16'hFFFF |=> st_r.wrap_irq && st_r.ovf ##1 !st_r.wrap_irq)
    else $error("wrap did not raise overflow");

  a_ovf_sticky: assert property (st_r.ovf && !(access_ph && pwrite
      && rd_idx == pwc_pkg::PWC_R_OPT0) |=> st_r.ovf)
    else $error("overflow flag dropped by itself");

  a_ovf_clear: assert property (access_ph && pwrite && rd_idx == pwc_pkg::PWC_R_OPT0
      && pstrb[0] && !pwdata[0] && !st_nxt.wrap_irq |=> !st_r.ovf)
    else $error("overflow flag not cleared");

  a_cnt_read: assert property (setup_ph && !pwrite && rd_idx == pwc_pkg::PWC_R_CNT
      && ce |=> pready && prdata[15:0] == $past(st_r.cnt))
    else $error("counter readback wrong");

  a_sel_zeros: assert property (setup_ph && rd_idx == pwc_pkg::PWC_R_SEL |=>
      prdata[7:5] == 3'h0 && prdata[2:0] == 3'h0)
    else $error("unused selector bits not zero");

  a_edge_catch: assert property (ce && pw_mode && edge_hit[0] |=>
      st_r.pend[0] || st_r.cap_irq[0])
    else $error("valid edge not recorded");

  a_out_level: assert property (!st_r.ioc0[0] |=>
      timer_output_pin[0] == $past(st_r.ioc0[1]))
    else $error("disabled output not at level bit");

  sequence s_cap1_step;
    tick && st_r.started && pw_mode && st_r.pend[1];
  endsequence

  sequence s_cap1_done;
    st_r.cap_irq[1] && (st_r.cnt == 16'h0000);
  endsequence

  a_capture_copy1: assert property (s_cap1_step |=> s_cap1_done ##0
      (st_r.ccr1 == $past(st_r.cnt)))
    else $error("capture did not copy and clear counter on input 1");

  a_edge_catch1: assert property (ce && pw_mode && edge_hit[1] |=>
      st_r.pend[1] || st_r.cap_irq[1])
    else $error("valid edge on input 1 not recorded");

  a_pend_drop: assert property (!ce |=> st_r.pend == 2'h0)
    else $error("edge pending while counter stopped");

  a_first_step: assert property (tick && !st_r.started |=>
      st_r.started && st_r.cnt == 16'h0000)
    else $error("first count step did not leave stopped value");

  a_count_step: assert property (tick && st_r.started && !(pw_mode && st_r.pend != 2'h0)
      && st_r.cnt != 16'hFFFF |=> st_r.cnt == 16'($past(st_r.cnt) + 16'h0001))
    else $error("counter did not increment");

  a_no_step: assert property (ce && !tick |=> st_r.cnt == $past(st_r.cnt))
    else $error("counter moved between prescaled steps");

  a_wrap_only: assert property (st_r.wrap_irq |-> $past(st_r.cnt) == 16'hFFFF
      && $past(tick))
    else $error("overflow request without wrap");

  a_stop_read: assert property (setup_ph && !pwrite && rd_idx == pwc_pkg::PWC_R_CNT
      && !ce |=> prdata == 32'h00000000)
    else $error("stopped counter readback not zero");

  a_apb_answer: assert property (pready == $past(setup_ph))
    else $error("ready not one cycle after setup");

  a_bad_addr: assert property (setup_ph && rd_idx == pwc_pkg::PWC_R_NONE |=>
      pslverr && prdata == 32'h00000000)
    else $error("unmapped access not refused");

  a_out_level1: assert property (!st_r.ioc0[`PWC_OE1_POS] |=>
      timer_output_pin[1] == $past(st_r.ioc0[`PWC_OL1_POS]))
    else $error("disabled output 1 not at level bit");

  a_out_run: assert property (st_r.ioc0[`PWC_OE0_POS] && ce |=>
      timer_output_pin[0] != $past(st_r.ioc0[`PWC_OL0_POS]))
    else $error("running output did not invert level");

endmodule
`default_nettype wire

// >>> bench/pwc_pulse_src.sv
/*
  Pulse source standing in for a capture pin or a serial receive line.
  Assumes: driven by the bench on ref_clk; gap is held while go is high.
*/
`timescale 1ns/1ps
`default_nettype none
module pwc_pulse_src (
  // Clock and reset
  input  wire logic        ref_clk,
  input  wire logic        rstn,
  // Control
  input  wire logic        go,
  input  wire logic [15:0] gap,
  // Line
  output logic             line
);
  logic [15:0] cnt_r;
  // One-cycle high pulse every gap cycles, low between pulses
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      cnt_r <= 16'h0000;
      line  <= 1'b0;
    end else if (!go) begin
      cnt_r <= 16'h0000;
      line  <= 1'b0;
    end else begin
      cnt_r <= (cnt_r + 16'h0001 >= gap) ? 16'h0000 : cnt_r + 16'h0001;
      line  <= (cnt_r == 16'h0000);
    end
  end
endmodule
`default_nettype wire

// >>> bench/pwc_timer_tb.sv
/*
  Self-checking bench of the pulse width capture timer.
  Assumes: register map header on the include path; pulse source compiled.
*/
`timescale 1ns/1ps
`include "pwc_map.svh"
`default_nettype none
module pwc_timer_tb;
  logic        ref_clk, rstn, psel, penable, pwrite, pready, pslverr, err;
  logic        wrap_irq, line0, line1, go0, go1;
  logic [31:0] paddr, pwdata, prdata, rd;
  logic [3:0]  pstrb;
  logic [1:0]  capture_irq, timer_output_pin;
  logic [15:0] gap0, gap1, c_a;
  int          failures, total_checks, cyc, seen0, seen1, seed, k, snap;

  pwc_timer dut_u (.ref_clk(ref_clk), .rstn(rstn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .capture_input_0(line0),
    .capture_input_1(line1), .serial0_receive_line(line1), .serial1_receive_line(line0),
    .capture_irq(capture_irq), .wrap_irq(wrap_irq), .timer_output_pin(timer_output_pin));
  pwc_pulse_src src0_u (.ref_clk(ref_clk), .rstn(rstn), .go(go0), .gap(gap0), .line(line0));
  pwc_pulse_src src1_u (.ref_clk(ref_clk), .rstn(rstn), .go(go1), .gap(gap1), .line(line1));

  initial begin
    ref_clk = 1'b0;
    forever #20 ref_clk = ~ref_clk;
  end

  always @(posedge ref_clk) begin
    cyc++;
    seen0 += (capture_irq[0] === 1'b1);
    seen1 += (capture_irq[1] === 1'b1);
    if (cyc == 95000) begin
      failures++;
      stop_test();
    end
  end

  task automatic stop_test();
    $display("checks %0d mismatches %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    total_checks++;
    if (g !== e) begin
      failures++;
      $display("BAD %s expected %h seen %h", n, e, g);
    end
  endtask

  // One APB transfer, held until pready is sampled high
  task automatic apb(input logic w, input logic [31:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge ref_clk);
    psel   <= 1'b1;
    pwrite <= w;
    paddr  <= a;
    pwdata <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    do begin
      @(posedge ref_clk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (pready !== 1'b1) chk("apb ready", 32'h1, 32'h0);
    rd  = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wait_ev(input int s, input int lim);
    int   n;
    logic hit;
    n = 0;
    do begin
      @(negedge ref_clk);
      n++;
      hit = (s == 2) ? (wrap_irq === 1'b1) : (capture_irq[s] === 1'b1);
    end while (!hit && n < lim);
    if (!hit) chk("event wait", 32'h1, 32'h0);
  endtask

  // Expected capture for a steady period of g cycles, 2^s cycles per step, no wrap
  function automatic logic [31:0] exp_cap(input logic [15:0] g, input logic [2:0] s);
    return {16'h0000, 16'((g >> s) - 16'h0001)};
  endfunction

  initial begin
    seed = 32'hD71C;
    {rstn, psel, penable, pwrite, go0, go1} = 6'h00;
    paddr = 32'h0;
    pwdata = 32'h0;
    pstrb = 4'hF;
    gap0 = 16'h0010;
    gap1 = 16'h0032;
    repeat (8) @(posedge ref_clk);
    rstn <= 1'b1;
    apb(1'b0, `PWC_ADDR_SEL, 32'h0);
    chk("selector reset", 32'h00, rd);
    apb(1'b0, `PWC_ADDR_CNT, 32'h0);
    chk("counter stopped", 32'h0, rd);
    apb(1'b0, `PWC_ADDR_IOC0 + 32'h4, 32'h0);
    chk("unmapped error", 32'h1, {31'h0, err});
    apb(1'b1, `PWC_ADDR_SEL, 32'hFF);
    apb(1'b0, `PWC_ADDR_SEL, 32'h0);
    chk("selector bits", 32'h18, rd);
    apb(1'b1, `PWC_ADDR_SEL, 32'h00);
    apb(1'b1, `PWC_ADDR_IOC0, 32'h0A);
    repeat (3) @(negedge ref_clk);
    chk("pins disabled", 32'h3, {30'h0, timer_output_pin});
    apb(1'b1, `PWC_ADDR_IOC0, 32'h0F);
    repeat (3) @(negedge ref_clk);
    chk("pins stopped", 32'h3, {30'h0, timer_output_pin});
    apb(1'b1, `PWC_ADDR_CTL1, {24'h0, 5'h00, `PWC_MODE_PULSE_WIDTH});
    apb(1'b1, `PWC_ADDR_CTL0, 32'h80);
    apb(1'b0, `PWC_ADDR_CNT, 32'h0);
    c_a = rd[15:0] + 16'h0001;
    apb(1'b0, `PWC_ADDR_CNT, 32'h0);
    chk("counter runs", 32'h1, {31'h0, (rd[15:0] - c_a) < 16'h0008});
    repeat (2) @(negedge ref_clk);
    chk("pins running", 32'h0, {30'h0, timer_output_pin});
    apb(1'b1, `PWC_ADDR_IOC1, {30'h0, `PWC_EDGE_RISE});
    go1 <= 1'b1;
    for (k = 0; k < 5; k++) begin
      gap0 <= (k == 0) ? 16'h0008 : 16'h0014 + 16'($unsigned($random(seed)) % 180);
      go0 <= 1'b1;
      wait_ev(0, 400);
      wait_ev(0, 400);
      apb(1'b0, `PWC_ADDR_CCR0, 32'h0);
      chk("capture value", exp_cap(gap0, 3'h0), rd);
      go0 <= 1'b0;
      repeat (20) @(posedge ref_clk);
    end
    chk("unused input quiet", 32'h0, seen1);
    apb(1'b1, `PWC_ADDR_CTL1, 32'h00);
    snap = seen0;
    go0 <= 1'b1;
    repeat (200) @(posedge ref_clk);
    chk("other mode no capture", snap, seen0);
    go0 <= 1'b0;
    apb(1'b1, `PWC_ADDR_CTL1, {24'h0, 5'h00, `PWC_MODE_PULSE_WIDTH});
    apb(1'b1, `PWC_ADDR_CTL0, 32'h00);
    apb(1'b1, `PWC_ADDR_SEL, 32'h08);
    apb(1'b1, `PWC_ADDR_CTL0, 32'h80);
    wait_ev(0, 400);
    wait_ev(0, 400);
    apb(1'b0, `PWC_ADDR_CCR0, 32'h0);
    chk("routed capture", exp_cap(gap1, 3'h0), rd);
    apb(1'b1, `PWC_ADDR_CTL0, 32'h00);
    apb(1'b1, `PWC_ADDR_IOC1, {28'h0, `PWC_EDGE_RISE, `PWC_EDGE_NONE});
    apb(1'b1, `PWC_ADDR_SEL, 32'h10);
    gap0 <= 16'h0022;
    apb(1'b1, `PWC_ADDR_CTL0, 32'h81);
    go0 <= 1'b1;
    wait_ev(1, 400);
    wait_ev(1, 400);
    apb(1'b0, `PWC_ADDR_CCR1, 32'h0);
    chk("routed capture 1", exp_cap(gap0, 3'h1), rd);
    go0 <= 1'b0;
    go1 <= 1'b0;
    apb(1'b1, `PWC_ADDR_CTL0, 32'h00);
    apb(1'b1, `PWC_ADDR_SEL, 32'h00);
    apb(1'b1, `PWC_ADDR_IOC1, 32'h00);
    apb(1'b1, `PWC_ADDR_CTL0, 32'h80);
    apb(1'b1, `PWC_ADDR_OPT0, 32'h00);
    wait_ev(2, 70000);
    apb(1'b0, `PWC_ADDR_CNT, 32'h0);
    chk("wrap restart", 32'h1, {31'h0, rd[15:0] < 16'h0010});
    apb(1'b0, `PWC_ADDR_OPT0, 32'h0);
    chk("wrap flag set", 32'h1, {31'h0, rd[`PWC_OVF_POS]});
    apb(1'b1, `PWC_ADDR_OPT0, 32'h01);
    apb(1'b0, `PWC_ADDR_OPT0, 32'h0);
    chk("wrap flag kept", 32'h1, {31'h0, rd[`PWC_OVF_POS]});
    apb(1'b1, `PWC_ADDR_OPT0, 32'h00);
    apb(1'b0, `PWC_ADDR_OPT0, 32'h0);
    chk("wrap flag clear", 32'h0, {31'h0, rd[`PWC_OVF_POS]});
    stop_test();
  end
endmodule
`default_nettype wire
